/* hw/fsw_top.sv */
// Purpose: Status register and write-enable gating of a serial flash
// Assumes: Host frames instructions with chip select, whole bytes
// Notes:   Array itself is outside; this block decides accept or refuse
`timescale 1ns/1ps
`default_nettype none
module fsw_top import fsw_pkg::*; #(
   parameter int unsigned PROG_CYC    = 64,
   parameter int unsigned ERASE_CYC   = 256,
   parameter int unsigned CHIP_CYC    = 1024,
   parameter int unsigned NV_CYC      = 32,
   parameter bit          BOTTOM_AREA = 1'b0
) (
   input  wire logic  core_clk,
   input  wire logic  srst,
   input  wire logic  link_sclk,
   input  wire logic  link_cs_n,
   input  wire logic  link_si,
   input  wire logic  wp_n,
   input  wire logic  hold_rst_n,
   output logic       link_so_o,
   output logic       link_so_oe,
   output logic       quad_pins_enable,
   output logic [7:0] flash_status_reg
);
   fsw_state_e                  st_q;
   fsw_state_e                  st_d;
   fsw_cls_e                    run_cls_q;
   logic                        write_enable_latch_q;
   logic                        write_enable_latch_d;
   logic                        status_write_lock_q;
   logic                        quad_pins_enable_q;
   logic [FSW_PROT_W-1:0]       block_protect_q;
   logic [7:0]                  pend_q;
   logic [FSW_CNT_W-1:0]        cnt_q;
   logic                        reset_armed_q;
   logic                        cs_prev_q;
   logic [2:0]                  pins_s;
   logic [7:0]                  status_w;

   fsw_link_if lk ();

   fsw_link u_link (
      .link_sclk  (link_sclk),
      .link_cs_n  (link_cs_n),
      .link_si    (link_si),
      .link_so_o  (link_so_o),
      .link_so_oe (link_so_oe),
      .lk         (lk)
   );

   fsw_sync #(.W(3), .INIT(3'h7)) u_pins (
      .clk  (core_clk),
      .srst (srst),
      .d    ({link_cs_n, wp_n, hold_rst_n}),
      .q    (pins_s)
   );

   // Frame decode, valid in the first cycle the synchronised chip select reads high
   wire       cs_s       = pins_s[2];
   wire       wp_s       = pins_s[1];
   wire       hold_s     = pins_s[0];
   wire [7:0] op         = lk.opcode;
   wire       frame_end  = cs_s & ~cs_prev_q;
   // Frames with a partial byte are dropped whole, a torn instruction must not write
   wire       ev         = frame_end & lk.whole & (lk.nbytes != 3'h0);
   fsw_cls_e  cls_w;
   assign cls_w = fsw_op_class(op);

   wire busy_flag  = st_q == FSW_ST_BUSY;
   wire is_idle    = st_q == FSW_ST_IDLE;
   wire is_susp    = st_q == FSW_ST_SUSP;
   wire is_arr     = cls_w == FSW_CLS_PROG || cls_w == FSW_CLS_ERASE;
   wire is_chip    = cls_w == FSW_CLS_CHIP;
   wire is_wrsts   = cls_w == FSW_CLS_WRSTS;
   wire run_arr    = run_cls_q == FSW_CLS_PROG || run_cls_q == FSW_CLS_ERASE
                     || run_cls_q == FSW_CLS_CHIP;

   // In quad mode both control pins carry data, so they lose their function
   wire wp_eff     = quad_pins_enable_q | wp_s;
   wire hw_rst     = ~quad_pins_enable_q & ~hold_s;

   // Protected area, counted from the top or the bottom of the array
   // Address is 24 bits wide, so the upper block bits read as zero
   wire [FSW_BLK_W-1:0] blk_w    = FSW_BLK_W'(lk.addr[FSW_ADDR_W-1:FSW_BLK_LSB]);
   wire [FSW_BLK_W:0]   prot_cnt = FSW_PROT_CNT[block_protect_q];
   wire prot_hit = BOTTOM_AREA ? ({1'b0, blk_w} < prot_cnt)
                               : ({1'b0, blk_w} >= FSW_BLK_TOTAL - prot_cnt);

   wire [2:0] len_need = cls_w == FSW_CLS_PROG  ? FSW_LEN_PROG
                       : cls_w == FSW_CLS_ERASE ? FSW_LEN_ERASE
                       : is_wrsts               ? FSW_LEN_WRSTS
                       : FSW_LEN_MIN;
   wire len_ok    = lk.nbytes >= len_need;
   wire wrsts_lck = status_write_lock_q & ~wp_eff;
   wire refuse    = (is_arr & prot_hit)
                  | (is_chip & block_protect_q != '0)
                  | (is_wrsts & wrsts_lck);
   // Every classified instruction needs the latch first
   wire wel_ok    = cls_w != FSW_CLS_NONE && write_enable_latch_q;
   // Volatile writes land outside this block, so they never go busy
   wire start     = ev & is_idle & wel_ok & len_ok & ~refuse & cls_w != FSW_CLS_VOL;

   wire cmd_write_enable_cmd  = ev & ~busy_flag & op == FSW_WRITE_ENABLE_CMD;
   wire cmd_write_disable_cmd  = ev & ~busy_flag & op == FSW_WRITE_DISABLE_CMD;
   wire cmd_susp  = ev & busy_flag & run_arr
                    & (op == FSW_SUSPEND_A_CMD | op == FSW_SUSPEND_B_CMD);
   wire cmd_res   = ev & is_susp & (op == FSW_RESUME_A_CMD | op == FSW_RESUME_B_CMD);
   wire soft_rst  = ev & reset_armed_q & op == FSW_RESET_DO_CMD;
   wire abort     = hw_rst | soft_rst;
   wire done      = busy_flag & cnt_q == FSW_CNT_ONE;

   wire [FSW_CNT_W-1:0] load_cnt = cls_w == FSW_CLS_PROG  ? FSW_CNT_W'(PROG_CYC)
                                 : cls_w == FSW_CLS_ERASE ? FSW_CNT_W'(ERASE_CYC)
                                 : is_chip                ? FSW_CNT_W'(CHIP_CYC)
                                 : FSW_CNT_W'(NV_CYC);

   always_comb begin
      st_d = st_q;
      case (st_q)
         FSW_ST_IDLE: begin
            if (start) begin
               st_d = FSW_ST_BUSY;
            end
         end
         FSW_ST_BUSY: begin
            if (done) begin
               st_d = FSW_ST_IDLE;
            end else if (cmd_susp) begin
               st_d = FSW_ST_SUSP;
            end
         end
         FSW_ST_SUSP: begin
            if (cmd_res) begin
               st_d = FSW_ST_BUSY;
            end
         end
         default: st_d = FSW_ST_IDLE;
      endcase
      if (abort) begin
         st_d = FSW_ST_IDLE;
      end
   end

   // Only the enable instruction sets by command; the disable and reset instructions clear
   always_comb begin
      write_enable_latch_d = write_enable_latch_q;
      if (abort || (done && run_cls_q != FSW_CLS_VOL)) begin
         write_enable_latch_d = 1'b0;
      end else if (cmd_write_enable_cmd) begin
         write_enable_latch_d = 1'b1;
      end else if (cmd_write_disable_cmd) begin
         write_enable_latch_d = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_q                 <= FSW_ST_IDLE;
         write_enable_latch_q <= FSW_STATUS_RST[FSW_WEL_BIT];
         cs_prev_q            <= 1'b1;
         reset_armed_q        <= 1'b0;
      end else begin
         st_q                 <= st_d;
         write_enable_latch_q <= write_enable_latch_d;
         cs_prev_q            <= cs_s;
         if (abort) begin
            reset_armed_q <= 1'b0;
         end else if (ev) begin
            reset_armed_q <= op == FSW_RESET_ARM_CMD;
         end
      end
   end

   // Timer pauses while suspended, resumes where it stopped
   always_ff @(posedge core_clk) begin
      if (srst || abort) begin
         cnt_q     <= '0;
         run_cls_q <= FSW_CLS_NONE;
      end else if (start) begin
         cnt_q     <= load_cnt;
         run_cls_q <= cls_w;
      end else if (busy_flag && !done) begin
         cnt_q     <= cnt_q - FSW_CNT_ONE;
      end
   end

   // New status bits take effect only when the write cycle ends
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pend_q              <= FSW_STATUS_RST;
         status_write_lock_q <= FSW_STATUS_RST[FSW_LOCK_BIT];
         quad_pins_enable_q  <= FSW_STATUS_RST[FSW_QUAD_BIT];
         block_protect_q     <= FSW_STATUS_RST[FSW_PROT_LSB +: FSW_PROT_W];
      end else begin
         if (start && is_wrsts) begin
            pend_q <= lk.data;
         end
         if (done && !abort && run_cls_q == FSW_CLS_WRSTS) begin
            status_write_lock_q <= pend_q[FSW_LOCK_BIT];
            quad_pins_enable_q  <= pend_q[FSW_QUAD_BIT];
            block_protect_q     <= pend_q[FSW_PROT_LSB +: FSW_PROT_W];
         end
      end
   end

   assign status_w[FSW_LOCK_BIT]                 = status_write_lock_q;
   assign status_w[FSW_QUAD_BIT]                 = quad_pins_enable_q;
   assign status_w[FSW_PROT_LSB +: FSW_PROT_W]   = block_protect_q;
   assign status_w[FSW_WEL_BIT]                  = write_enable_latch_q;
   assign status_w[FSW_BUSY_BIT]                 = busy_flag;
   assign lk.status                              = status_w;
   assign flash_status_reg                       = status_w;
   assign quad_pins_enable                       = quad_pins_enable_q;

   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence s_enter_busy;
      ##1 busy_flag;
   endsequence

   sequence s_parked;
      ##1 is_susp && !busy_flag ##1 $stable(cnt_q);
   endsequence

   sequence s_untouched;
      ##1 is_idle && $stable(block_protect_q) && $stable(status_write_lock_q);
   endsequence

   a_busy_start: assert property (
      start && !abort |-> s_enter_busy)
      else $error("write operation did not go busy");

   a_busy_source: assert property (
      $rose(busy_flag) |-> $past(start) || $past(cmd_res))
      else $error("busy rose without an accepted operation");

   a_ready_clear: assert property (
      done && !abort && run_cls_q != FSW_CLS_VOL |=> !busy_flag && !write_enable_latch_q)
      else $error("completion left busy or latch set");

   a_busy_ignore: assert property (
      busy_flag && ev && !done && !abort |=> $stable(write_enable_latch_q)
         && $stable(block_protect_q) && $stable(run_cls_q))
      else $error("instruction acted on while busy");

   a_suspend_go: assert property (
      cmd_susp && !done && !abort |-> s_parked)
      else $error("suspend not taken or timer moved");

   a_latch_gate: assert property (
      ev && is_idle && cls_w != FSW_CLS_NONE && !write_enable_latch_q && !abort
         |-> s_untouched)
      else $error("write accepted without latch");

   a_latch_set: assert property (
      ev && is_idle && op == FSW_WRITE_ENABLE_CMD && !abort |=> write_enable_latch_q)
      else $error("write enable did not set latch");

   a_latch_clear: assert property (
      ev && is_idle && op == FSW_WRITE_DISABLE_CMD && !abort |=> !write_enable_latch_q)
      else $error("write disable did not clear latch");

   a_status_keep: assert property (
      start && is_wrsts && !abort |=> write_enable_latch_q[*2])
      else $error("status write disturbed the latch");

   a_status_apply: assert property (
      done && !abort && run_cls_q == FSW_CLS_WRSTS
         |=> block_protect_q == $past(pend_q[FSW_PROT_LSB +: FSW_PROT_W])
         && quad_pins_enable_q == $past(pend_q[FSW_QUAD_BIT]))
      else $error("status write not applied");

   a_lock_hold: assert property (
      ev && is_idle && is_wrsts && wrsts_lck && !abort |-> s_untouched)
      else $error("locked status was written");

   a_chip_guard: assert property (
      ev && is_idle && is_chip && block_protect_q != '0 && !abort |=> is_idle)
      else $error("chip erase ran with protection set");

   a_area_guard: assert property (
      ev && is_idle && is_arr && prot_hit && !abort |=> is_idle)
      else $error("protected area was written");
endmodule
`default_nettype wire

/* hw/fsw_pkg.sv */
// Purpose: Shared constants, opcode classes and types of the flash status block
// Assumes: Instructions are single bytes shifted MSB first
// Notes:   Status byte layout follows the bit positions below
package fsw_pkg;
   localparam int FSW_BUSY_BIT = 0;
   localparam int FSW_WEL_BIT  = 1;
   localparam int FSW_PROT_LSB = 2;
   localparam int FSW_PROT_W   = 4;
   localparam int FSW_QUAD_BIT = 6;
   localparam int FSW_LOCK_BIT = 7;
   localparam int FSW_ADDR_W   = 24;
   localparam int FSW_BLK_LSB  = 16;
   localparam int FSW_BLK_W    = 10;
   localparam int FSW_CNT_W    = 16;

   localparam logic [7:0]           FSW_STATUS_RST    = 8'h00;
   localparam logic [FSW_BLK_W:0]   FSW_BLK_TOTAL     = 11'h400;
   localparam logic [FSW_CNT_W-1:0] FSW_CNT_ONE       = 16'h0001;

   localparam logic [7:0] FSW_WRITE_ENABLE_CMD  = 8'h06;
   localparam logic [7:0] FSW_WRITE_DISABLE_CMD = 8'h04;
   localparam logic [7:0] FSW_STATUS_READ_CMD   = 8'h05;
   localparam logic [7:0] FSW_SUSPEND_A_CMD     = 8'h75;
   localparam logic [7:0] FSW_SUSPEND_B_CMD     = 8'hB0;
   localparam logic [7:0] FSW_RESUME_A_CMD      = 8'h7A;
   localparam logic [7:0] FSW_RESUME_B_CMD      = 8'h30;
   localparam logic [7:0] FSW_RESET_ARM_CMD     = 8'h66;
   localparam logic [7:0] FSW_RESET_DO_CMD      = 8'h99;

   // Whole bytes needed per class: opcode, address, data
   localparam logic [2:0] FSW_LEN_PROG  = 3'h5;
   localparam logic [2:0] FSW_LEN_ERASE = 3'h4;
   localparam logic [2:0] FSW_LEN_WRSTS = 3'h2;
   localparam logic [2:0] FSW_LEN_MIN   = 3'h1;

   // Protected block count per protect field value
   localparam logic [FSW_BLK_W:0] FSW_PROT_CNT [16] = '{
      11'h000, 11'h001, 11'h002, 11'h004, 11'h008, 11'h010, 11'h020, 11'h040,
      11'h080, 11'h100, 11'h200, 11'h300, 11'h380, 11'h3C0, 11'h3E0, 11'h400};

   typedef enum logic [2:0] {
      FSW_ST_IDLE = 3'b001,
      FSW_ST_BUSY = 3'b010,
      FSW_ST_SUSP = 3'b100
   } fsw_state_e;

   typedef enum logic [2:0] {
      FSW_CLS_NONE, FSW_CLS_PROG, FSW_CLS_ERASE, FSW_CLS_CHIP,
      FSW_CLS_NV, FSW_CLS_VOL, FSW_CLS_WRSTS
   } fsw_cls_e;

   function automatic fsw_cls_e fsw_op_class(input logic [7:0] op);
      case (op)
         8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E: fsw_op_class = FSW_CLS_PROG;
         8'hD7, 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC: fsw_op_class = FSW_CLS_ERASE;
         8'hC7, 8'h60: fsw_op_class = FSW_CLS_CHIP;
         8'h01: fsw_op_class = FSW_CLS_WRSTS;
         8'h63, 8'h83, 8'hC5, 8'h4A, 8'hFB, 8'hE1: fsw_op_class = FSW_CLS_VOL;
         8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h18, 8'hFD, 8'hE3, 8'hE4,
         8'h2F, 8'hA6, 8'h91, 8'h7E, 8'h98, 8'hE8, 8'h43, 8'hB5: fsw_op_class = FSW_CLS_NV;
         default: fsw_op_class = FSW_CLS_NONE;
      endcase
   endfunction
endpackage

/* hw/fsw_link_if.sv */
// Purpose: Frame results from the serial link to the core, status back
// Assumes: Frame fields are stable while chip select is high
// Notes:   Status is sampled on the link clock through a synchroniser
`timescale 1ns/1ps
`default_nettype none
interface fsw_link_if;
   logic [7:0]                     opcode;
   logic [7:0]                     data;
   logic [fsw_pkg::FSW_ADDR_W-1:0] addr;
   logic [2:0]                     nbytes;
   logic                           whole;
   logic [7:0]                     status;
   modport link (output opcode, data, addr, nbytes, whole, input status);
   modport core (input opcode, data, addr, nbytes, whole, output status);
endinterface
`default_nettype wire

/* hw/fsw_sync.sv */
// Purpose: Two-flop synchroniser for independent level signals
// Assumes: Each bit is meaningful on its own
// Notes:   Only the second flop is visible outside
`timescale 1ns/1ps
`default_nettype none
module fsw_sync #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= INIT;
         q      <= INIT;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* hw/fsw_link.sv */
// Purpose: Serial shifter on the link clock, mode 0 or 3
// Assumes: Link clock only toggles while chip select is low
// Notes:   Frame fields hold after the frame for the core to pick up
`timescale 1ns/1ps
`default_nettype none
module fsw_link import fsw_pkg::*; (
   input  wire logic   link_sclk,
   input  wire logic   link_cs_n,
   input  wire logic   link_si,
   output logic        link_so_o,
   output logic        link_so_oe,
   fsw_link_if.link    lk
);
   logic                  in_frame_q;
   logic [2:0]            bcnt_q;
   logic [2:0]            nbytes_q;
   logic [6:0]            sh_q;
   logic [7:0]            opcode_q;
   logic [7:0]            data_q;
   logic [7:0]            snap_q;
   logic [FSW_ADDR_W-1:0] addr_q;
   logic                  rd_q;
   logic                  so_q;
   logic [7:0]            stat_s;

   wire [7:0] byte_w   = {sh_q, link_si};
   wire       byte_end = in_frame_q && bcnt_q == 3'h7;
   wire       first    = byte_end && nbytes_q == 3'h0;

   fsw_sync #(.W(8), .INIT(FSW_STATUS_RST)) u_stat (
      .clk  (link_sclk),
      .srst (1'b0),
      .d    (lk.status),
      .q    (stat_s)
   );

   // Cleared by chip select itself, since the clock stops after the frame
   always_ff @(posedge link_sclk or posedge link_cs_n) begin
      if (link_cs_n) begin
         in_frame_q <= 1'b0;
      end else begin
         in_frame_q <= 1'b1;
      end
   end

   always_ff @(posedge link_sclk) begin
      sh_q   <= byte_w[6:0];
      bcnt_q <= in_frame_q ? bcnt_q + 3'h1 : 3'h1;
      if (!in_frame_q) begin
         nbytes_q <= 3'h0;
         rd_q     <= 1'b0;
      end else if (byte_end && nbytes_q != 3'h7) begin
         nbytes_q <= nbytes_q + 3'h1;
      end
      if (first) begin
         opcode_q <= byte_w;
         rd_q     <= byte_w == FSW_STATUS_READ_CMD;
         snap_q   <= stat_s;
      end
      if (byte_end && nbytes_q == 3'h1) begin
         data_q <= byte_w;
      end
      if (byte_end && nbytes_q != 3'h0 && nbytes_q < FSW_LEN_ERASE) begin
         addr_q <= {addr_q[FSW_ADDR_W-9:0], byte_w};
      end
   end

   // One snapshot per frame, shifted out again every byte
   always_ff @(negedge link_sclk) begin
      so_q <= snap_q[~bcnt_q];
   end

   assign link_so_o  = so_q;
   assign link_so_oe = rd_q & in_frame_q & ~link_cs_n;
   assign lk.opcode  = opcode_q;
   assign lk.data    = data_q;
   assign lk.addr    = addr_q;
   assign lk.nbytes  = nbytes_q;
   assign lk.whole   = bcnt_q == 3'h0;

   a_repeat_read: assert property (
      @(negedge link_sclk) disable iff (link_cs_n)
      rd_q && nbytes_q >= 3'h3 |-> so_q == $past(so_q, 8))
      else $error("status read did not repeat");
endmodule
`default_nettype wire

/* test/fsw_host.sv */
// Purpose: Host model of the serial link, mode 0 frames
// Assumes: Whole bytes, MSB first, 80 ns link clock
// Notes:   Clock stays low outside frames; released line toggles
`timescale 1ns/1ps
`default_nettype none
module fsw_host (
   output logic      link_sclk,
   output logic      link_cs_n,
   output logic      link_si,
   input  wire logic link_so_o,
   input  wire logic link_so_oe
);
   logic so_last;
   logic so_line;
   // Undriven line must not look like valid data
   assign so_line = link_so_oe ? link_so_o : ~so_last;
   always @(posedge link_sclk) so_last <= so_line;
   initial begin
      link_sclk = 1'b0;
      link_cs_n = 1'b1;
      link_si   = 1'b0;
      so_last   = 1'b0;
   end
   task automatic frame(input logic [39:0] v, input int nbytes, output logic [15:0] rd);
      int i;
      rd = 16'h0000;
      #13 link_cs_n = 1'b0;
      for (i = 0; i < nbytes * 8; i++) begin
         #20 link_si = v[39-i];
         #20 link_sclk = 1'b1;
         rd = {rd[14:0], so_line};
         #40 link_sclk = 1'b0;
      end
      #20 link_cs_n = 1'b1;
      // Gap well above five core cycles
      #300;
   endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Purpose: Checks status bits and write-enable gating over the link
// Assumes: Long operation counts shortened to 800 core cycles
// Notes:   Status checked on the port and by serial read
`timescale 1ns/1ps
`default_nettype none
module tb import fsw_pkg::*;;
   logic        core_clk;
   logic        srst;
   logic        wp_n;
   logic        hold_n;
   wire logic   sclk;
   wire logic   cs_n;
   wire logic   si;
   wire logic   so;
   wire logic   so_oe;
   wire logic   quad;
   wire logic [7:0] st;
   logic [15:0] rd;
   int          failures;
   int          total_checks;
   int          cyc;
   fsw_top #(.PROG_CYC(800), .ERASE_CYC(800), .CHIP_CYC(800), .NV_CYC(800), .BOTTOM_AREA(1'b0)) DUT (
      .core_clk(core_clk), .srst(srst), .link_sclk(sclk), .link_cs_n(cs_n), .link_si(si), .wp_n(wp_n),
      .hold_rst_n(hold_n), .link_so_o(so), .link_so_oe(so_oe), .quad_pins_enable(quad), .flash_status_reg(st));
   fsw_host host (.link_sclk(sclk), .link_cs_n(cs_n), .link_si(si), .link_so_o(so), .link_so_oe(so_oe));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_st(input logic [7:0] exp);
      @(negedge core_clk);
      chk(st, exp);
   endtask
   task automatic cmd(input logic [7:0] op);
      host.frame({op, 32'h0}, 1, rd);
   endtask
   task automatic wr_st(input logic [7:0] d);
      host.frame({8'h01, d, 24'h0}, 2, rd);
   endtask
   task automatic rd_st(input logic [7:0] exp);
      host.frame({FSW_STATUS_READ_CMD, 32'h0}, 3, rd);
      chk(rd[15:8], exp);
      chk(rd[7:0], exp);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge core_clk);
      while (st[FSW_BUSY_BIT] !== 1'b0 && n < 3000) begin
         @(negedge core_clk);
         n++;
      end
      chk({7'h00, st[FSW_BUSY_BIT]}, 8'h00);
   endtask
   task automatic endt(input string nm);
      $display("test %0s done", nm);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      failures = 0;
      total_checks = 0;
      cyc = 0;
      srst = 1'b1;
      wp_n = 1'b1;
      hold_n = 1'b1;
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      chk_st(8'h00);
      chk({7'h00, quad}, 8'h00);
      host.frame({8'h02, 24'h000000, 8'hA5}, 5, rd);
      chk_st(8'h00);
      cmd(FSW_WRITE_ENABLE_CMD);
      chk_st(8'h02);
      cmd(FSW_WRITE_DISABLE_CMD);
      chk_st(8'h00);
      endt("latch");
      cmd(FSW_WRITE_ENABLE_CMD);
      wr_st(8'h43);
      chk_st(8'h03);
      cmd(FSW_WRITE_DISABLE_CMD);
      chk_st(8'h03);
      rd_st(8'h03);
      wait_idle();
      chk_st(8'h40);
      chk({7'h00, quad}, 8'h01);
      rd_st(8'h40);
      endt("quad");
      cmd(FSW_WRITE_ENABLE_CMD);
      wr_st(8'h30);
      wait_idle();
      chk_st(8'h30);
      cmd(FSW_WRITE_ENABLE_CMD);
      host.frame({8'hC7, 32'h0}, 1, rd);
      chk_st(8'h32);
      host.frame({8'hD8, 24'h800000, 8'h00}, 4, rd);
      chk_st(8'h32);
      host.frame({8'hD8, 24'h000000, 8'h00}, 4, rd);
      chk_st(8'h33);
      wait_idle();
      chk_st(8'h30);
      endt("protect");
      cmd(FSW_WRITE_ENABLE_CMD);
      wr_st(8'hB0);
      wait_idle();
      @(posedge core_clk);
      wp_n <= 1'b0;
      cmd(FSW_WRITE_ENABLE_CMD);
      wr_st(8'h00);
      chk_st(8'hB2);
      @(posedge core_clk);
      wp_n <= 1'b1;
      wr_st(8'h00);
      wait_idle();
      chk_st(8'h00);
      endt("lock");
      cmd(FSW_WRITE_ENABLE_CMD);
      host.frame({8'h02, 24'h000000, 8'hA5}, 5, rd);
      chk_st(8'h03);
      cmd(FSW_SUSPEND_A_CMD);
      chk_st(8'h02);
      cmd(FSW_RESUME_A_CMD);
      chk_st(8'h03);
      wait_idle();
      chk_st(8'h00);
      endt("suspend");
      cmd(FSW_WRITE_ENABLE_CMD);
      host.frame({8'h02, 24'h000000, 8'hA5}, 5, rd);
      chk_st(8'h03);
      @(posedge core_clk);
      hold_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk_st(8'h00);
      @(posedge core_clk);
      hold_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      endt("hold");
      tally_and_finish();
   end
endmodule
`default_nettype wire
